// ---- core/opdec_params.svh ----
// Constants for the first-page opcode decoder and bus cycle sequencer
`ifndef OPDEC_PARAMS_SVH
`define OPDEC_PARAMS_SVH
`define OPC_PREFIX_PAGE2 8'h9E
`define OPC_BRANCH_ALWAYS 8'h20
`define OPC_ADD_SP 8'hA7
`define OPC_ADD_X 8'hAF
`define OPC_BRANCH_SUB 8'hAD
`define OPC_ILLEGAL_AC 8'hAC
`define VEC_PAGE 8'hFF
`define NIB_BITOPS 4'h0
`define NIB_BITSET 4'h1
`define NIB_BRANCH 4'h2
`define NIB_CONST 4'hA
`define NIB_DIR 4'hB
`define NIB_FULL 4'hC
`define NIB_IDX_WORD 4'hD
`define NIB_IDX_BYTE 4'hE
`define NIB_IDX 4'hF
`define LOW_STORE_A 4'h7
`define LOW_STORE_X 4'hF
`define RESET_PC 16'h0000
`endif

// ---- core/opdec_pkg.sv ----
// Types shared by the opcode decoder files
package opdec_pkg;
  typedef enum logic [4:0] {
    OP_NONE, OP_BR_IF_SET, OP_BR_IF_CLR, OP_SET_BIT, OP_CLR_BIT, OP_BRANCH, OP_SUB,
    OP_COMPARE_A, OP_SUB_BORROW, OP_COMPARE_X, OP_AND, OP_BIT, OP_LOAD_A, OP_STORE_A,
    OP_XOR_A, OP_ADC, OP_OR_A, OP_ADD, OP_JUMP, OP_JUMP_SUB, OP_LOAD_X, OP_STORE_X,
    OP_ADD_SP, OP_ADD_X, OP_BRANCH_SUB, OP_PREFIX
  } op_e;
  typedef enum logic [3:0] {
    AM_NONE, AM_DIR, AM_REL, AM_CONST, AM_FULL, AM_IDX_WORD, AM_IDX_BYTE, AM_IDX
  } mode_e;
  typedef enum logic [2:0] {
    CYC_FREE, CYC_PROG, CYC_READ, CYC_WRITE, CYC_PUSH, CYC_POP, CYC_VEC
  } cyc_e;
endpackage : opdec_pkg

// ---- core/opcode_table.sv ----
// Combinational first-page opcode table
`include "opdec_params.svh"
module opcode_table
  import opdec_pkg::*;
(
  input  wire logic [7:0] opcode_in,
  output op_e             op_out,
  output mode_e           mode_out,
  output logic [1:0]      len_out,
  output logic [3:0]      cycles_out,
  output logic [2:0]      bitnum_out,
  output logic            illegal_out
);
  logic [3:0] hi;
  logic [3:0] lo;
  assign hi = opcode_in[7:4];
  assign lo = opcode_in[3:0];
  assign bitnum_out = opcode_in[3:1];

  // Operation per low nibble of register/memory group
  // low nibble operation
  function automatic op_e rm_op(input logic [3:0] n);
    op_e t[16];
    t = '{OP_SUB, OP_COMPARE_A, OP_SUB_BORROW, OP_COMPARE_X, OP_AND, OP_BIT, OP_LOAD_A,
          OP_STORE_A, OP_XOR_A, OP_ADC, OP_OR_A, OP_ADD, OP_JUMP, OP_JUMP_SUB, OP_LOAD_X,
          OP_STORE_X};
    return t[n];
  endfunction : rm_op

  // Group decode
  always_comb begin
    op_out      = OP_NONE;
    mode_out    = AM_NONE;
    len_out     = 2'd0;
    cycles_out  = 4'd0;
    illegal_out = 1'b0;
    if (opcode_in == `OPC_PREFIX_PAGE2) begin
      op_out = OP_PREFIX;
      len_out = 2'd1;
      cycles_out = 4'd1;
    end else if (hi == `NIB_BITOPS) begin
      op_out = opcode_in[0] ? OP_BR_IF_CLR : OP_BR_IF_SET;
      mode_out = AM_DIR;
      len_out = 2'd3;
      cycles_out = 4'd5;
    end else if (hi == `NIB_BITSET) begin
      op_out = opcode_in[0] ? OP_CLR_BIT : OP_SET_BIT;
      mode_out = AM_DIR;
      len_out = 2'd2;
      cycles_out = 4'd5;
    end else if (hi == `NIB_BRANCH) begin
      op_out = OP_BRANCH;
      mode_out = AM_REL;
      len_out = 2'd2;
      cycles_out = 4'd3;
    end else if (hi >= `NIB_CONST) begin
      op_out = rm_op(lo);
      unique case (hi)
        `NIB_CONST:    begin mode_out = AM_CONST;    len_out = 2'd2; cycles_out = 4'd2; end
        `NIB_DIR:      begin mode_out = AM_DIR;      len_out = 2'd2; cycles_out = 4'd3; end
        `NIB_FULL:     begin mode_out = AM_FULL;     len_out = 2'd3; cycles_out = 4'd4; end
        `NIB_IDX_WORD: begin mode_out = AM_IDX_WORD; len_out = 2'd3; cycles_out = 4'd4; end
        `NIB_IDX_BYTE: begin mode_out = AM_IDX_BYTE; len_out = 2'd2; cycles_out = 4'd3; end
        default:       begin mode_out = AM_IDX;      len_out = 2'd1; cycles_out = 4'd3; end
      endcase
      if (hi == `NIB_IDX && (lo == `LOW_STORE_A || lo == `LOW_STORE_X)) cycles_out = 4'd2;
      if (opcode_in == `OPC_ADD_SP) op_out = OP_ADD_SP;
      if (opcode_in == `OPC_ADD_X) op_out = OP_ADD_X;
      if (opcode_in == `OPC_BRANCH_SUB) begin
        op_out = OP_BRANCH_SUB;
        mode_out = AM_REL;
        cycles_out = 4'd5;
      end
      // the one unassigned code in the group
      if (opcode_in == `OPC_ILLEGAL_AC) begin
        op_out = OP_NONE;
        illegal_out = 1'b1;
      end
    end else begin
      illegal_out = 1'b1;
    end
  end
endmodule : opcode_table

// ---- core/cpu_opcode_decoder.sv ----
// Opcode decoder and bus cycle sequencer
`include "opdec_params.svh"
// How it works
// - A free cycle lasts one clock and is shown as a read.
// - Each program fetch reads the next sequential program byte.
// - Each operand read or write moves exactly one byte.
// - A push writes one stack byte.
// - Vector cycles read the top page, high byte then low byte.
// - Codes 00..0F are bit-test branches, zero page, three bytes, five cycles.
// - Codes 10..1F set or clear a memory bit; bits 3..1 name the bit.
// - Codes 2x are relative branches, two bytes, three cycles; 20 always jumps.
// - Nibble A is inline constant, nibble B is zero page.
// - Nibble C is full address, nibble D is word-offset indexed.
// - Nibble E is byte-offset indexed, nibble F is no-offset indexed.
// - The low nibble picks the register/memory operation in fixed order.
// - A7, AF, AD and no-offset stores have their own decode.
// - Byte 9E selects the second page for the next byte.
module cpu_opcode_decoder
  import opdec_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        ce_in,
  input  wire logic        opcode_valid_in,
  input  wire logic [7:0]  opcode_in,
  input  wire logic        vector_req_in,
  input  wire logic [7:0]  vector_sel_in,
  input  wire logic [15:0] oper_addr_in,
  input  wire logic [15:0] sp_in,
  input  wire logic [7:0]  wdata_in,
  output logic [15:0]      bus_addr_out,
  output logic             bus_rd_out,
  output logic [7:0]       bus_wdata_out,
  output cyc_e             cyc_kind_out,
  output op_e              op_out,
  output mode_e            mode_out,
  output logic [1:0]       len_out,
  output logic [3:0]       cycles_out,
  output logic [2:0]       bitnum_out,
  output logic             page2_out,
  output logic             illegal_out,
  output logic             busy_out
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_FETCH = 4'b0010, ST_EXEC = 4'b0100, ST_VEC = 4'b1000
  } state_e;

  state_e      state_r;
  logic [15:0] pc_r;
  logic [3:0]  left_r;
  logic        vec_hi_r;
  logic        page2_r;
  op_e         t_op;
  mode_e       t_mode;
  logic [1:0]  t_len;
  logic [3:0]  t_cyc;
  logic [2:0]  t_bit;
  logic        t_ill;
  logic        take;

  opcode_table u_table (
    .opcode_in   (opcode_in),
    .op_out      (t_op),
    .mode_out    (t_mode),
    .len_out     (t_len),
    .cycles_out  (t_cyc),
    .bitnum_out  (t_bit),
    .illegal_out (t_ill)
  );

  // Vector request wins, so no decode is captured alongside it
  assign take     = ce_in && state_r == ST_IDLE && opcode_valid_in && !vector_req_in;
  assign busy_out = state_r != ST_IDLE;

  // Kind of bus cycle for a step of the instruction
  function automatic cyc_e step_kind(input op_e op, input logic [3:0] left);
    if (op == OP_STORE_A || op == OP_STORE_X || op == OP_SET_BIT || op == OP_CLR_BIT)
      return (left == 4'd1) ? CYC_WRITE : CYC_READ;
    if (op == OP_JUMP_SUB || op == OP_BRANCH_SUB)
      return (left <= 4'd2) ? CYC_PUSH : CYC_FREE;
    return (left == 4'd1) ? CYC_READ : CYC_FREE;
  endfunction : step_kind

  // Decode capture and prefix tracking
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      op_out      <= OP_NONE;
      mode_out    <= AM_NONE;
      len_out     <= 2'd0;
      cycles_out  <= 4'd0;
      bitnum_out  <= 3'd0;
      illegal_out <= 1'b0;
      page2_r     <= 1'b0;
      page2_out   <= 1'b0;
    end else if (take) begin
      // second page bytes are not decoded; op and mode read as none
      page2_out   <= page2_r;
      page2_r     <= (opcode_in == `OPC_PREFIX_PAGE2) && !page2_r;
      op_out      <= page2_r ? OP_NONE : t_op;
      mode_out    <= page2_r ? AM_NONE : t_mode;
      len_out     <= t_len;
      cycles_out  <= t_cyc;
      bitnum_out  <= t_bit;
      illegal_out <= t_ill && !page2_r;
    end
  end

  // Cycle sequencer
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_r  <= ST_IDLE;
      pc_r     <= `RESET_PC;
      left_r   <= 4'd0;
      vec_hi_r <= 1'b0;
    end else if (ce_in) begin
      unique case (state_r)
        ST_IDLE: begin
          if (vector_req_in) begin
            state_r  <= ST_VEC;
            vec_hi_r <= 1'b1;
          end else if (opcode_valid_in) begin
            state_r <= ST_FETCH;
            left_r  <= t_cyc;
          end
        end
        ST_FETCH: begin
          pc_r    <= pc_r + 16'd1;
          left_r  <= left_r - 4'd1;
          state_r <= (left_r <= 4'd1) ? ST_IDLE : ST_EXEC;
        end
        ST_EXEC: begin
          left_r  <= left_r - 4'd1;
          if (left_r <= 4'd1) state_r <= ST_IDLE;
        end
        ST_VEC: begin
          vec_hi_r <= 1'b0;
          if (!vec_hi_r) state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Bus cycle outputs, one byte per cycle
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      bus_addr_out  <= 16'h0000;
      bus_rd_out    <= 1'b1;
      bus_wdata_out <= 8'h00;
      cyc_kind_out  <= CYC_FREE;
    end else if (ce_in) begin
      bus_rd_out   <= 1'b1;
      cyc_kind_out <= CYC_FREE;
      bus_addr_out <= pc_r;
      unique case (state_r)
        ST_FETCH: cyc_kind_out <= CYC_PROG;
        ST_EXEC: begin
          cyc_kind_out <= step_kind(op_out, left_r);
          if (step_kind(op_out, left_r) == CYC_READ) bus_addr_out <= oper_addr_in;
          if (step_kind(op_out, left_r) == CYC_WRITE) begin
            bus_addr_out  <= oper_addr_in;
            bus_rd_out    <= 1'b0;
            bus_wdata_out <= wdata_in;
          end
          if (step_kind(op_out, left_r) == CYC_PUSH) begin
            bus_addr_out  <= sp_in;
            bus_rd_out    <= 1'b0;
            bus_wdata_out <= left_r[0] ? pc_r[15:8] : pc_r[7:0];
          end
        end
        ST_VEC: begin
          cyc_kind_out <= CYC_VEC;
          bus_addr_out <= {`VEC_PAGE, vector_sel_in[7:1], !vec_hi_r};
        end
        default: ;
      endcase
    end
  end

  // a_free_read: free cycles are reads
  a_free_read: assert property (@(posedge clk_in) disable iff (srst_in)
    cyc_kind_out == CYC_FREE |-> bus_rd_out) else $error("free cycle not a read");
  // a_fetch_seq: PC steps by one per fetch
  a_fetch_seq: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && state_r == ST_FETCH |=> pc_r == $past(pc_r) + 16'd1)
    else $error("fetch not sequential");
  // a_write_kind: writes only on write or push cycles
  a_write_kind: assert property (@(posedge clk_in) disable iff (srst_in)
    !bus_rd_out |-> cyc_kind_out inside {CYC_WRITE, CYC_PUSH})
    else $error("write on wrong cycle");
  // a_vec_page: vector reads in top page
  a_vec_page: assert property (@(posedge clk_in) disable iff (srst_in)
    cyc_kind_out == CYC_VEC |-> bus_addr_out[15:8] == `VEC_PAGE && bus_rd_out)
    else $error("vector outside top page");
  // a_vec_order: high byte then low byte
  a_vec_order: assert property (@(posedge clk_in) disable iff (srst_in)
    ce_in && state_r == ST_IDLE && vector_req_in ##1 ce_in[*2] |=>
    $past(bus_addr_out[0]) == 1'b0 && bus_addr_out[0] == 1'b1)
    else $error("vector order wrong");
  // a_bit_branch_dec: bit branch decode
  a_bit_branch_dec: assert property (@(posedge clk_in) disable iff (srst_in)
    take && !page2_r && opcode_in[7:4] == `NIB_BITOPS |=>
    len_out == 2'd3 && cycles_out == 4'd5 && mode_out == AM_DIR)
    else $error("bit branch decode wrong");
  // a_branch_dec: relative branch decode
  a_branch_dec: assert property (@(posedge clk_in) disable iff (srst_in)
    take && !page2_r && opcode_in[7:4] == `NIB_BRANCH |=>
    op_out == OP_BRANCH && cycles_out == 4'd3) else $error("branch decode wrong");
  // a_full_dec: full address decode
  a_full_dec: assert property (@(posedge clk_in) disable iff (srst_in)
    take && !page2_r && opcode_in[7:4] == `NIB_FULL |=>
    mode_out == AM_FULL && len_out == 2'd3 && cycles_out == 4'd4)
    else $error("full address decode wrong");
  // a_prefix_page: byte after prefix marked second page
  a_prefix_page: assert property (@(posedge clk_in) disable iff (srst_in)
    take && !page2_r && opcode_in == `OPC_PREFIX_PAGE2 |=> page2_r)
    else $error("prefix not tracked");
  c_vector: cover property (@(posedge clk_in) cyc_kind_out == CYC_VEC);
  c_write: cover property (@(posedge clk_in) cyc_kind_out == CYC_WRITE);
  c_push: cover property (@(posedge clk_in) cyc_kind_out == CYC_PUSH);
  c_illegal: cover property (@(posedge clk_in) illegal_out);
endmodule : cpu_opcode_decoder

// ---- sim/bus_watch_model.sv ----
// Far-side model: memory and peripherals watching every system bus cycle
module bus_watch_model
  import opdec_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic [15:0] bus_addr_in,
  input  wire logic        bus_rd_in,
  input  wire logic [7:0]  bus_wdata_in,
  input  wire cyc_e        cyc_kind_in,
  output logic [7:0]       bad_count_out,
  output logic [7:0]       wr_count_out,
  output logic [7:0]       push_count_out,
  output logic [15:0]      wr_addr_out,
  output logic [7:0]       wr_data_out,
  output logic [31:0]      vec_pair_out
);
  logic [15:0] pc_r;
  // Judge each cycle by kind and keep the last writes and vector reads
  // cycle kinds honoured
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pc_r <= 16'hFFFF;
      bad_count_out <= 8'h00;
      wr_count_out <= 8'h00;
      push_count_out <= 8'h00;
      wr_addr_out <= 16'h0000;
      wr_data_out <= 8'h00;
      vec_pair_out <= 32'h0000_0000;
    end else begin
      case (cyc_kind_in)
        CYC_PROG: begin
          if (bus_rd_in !== 1'b1 || bus_addr_in !== pc_r + 16'h0001) bad_count_out <= bad_count_out + 8'h01;
          pc_r <= bus_addr_in;
        end
        CYC_WRITE, CYC_PUSH: begin
          if (bus_rd_in !== 1'b0) bad_count_out <= bad_count_out + 8'h01;
          if (cyc_kind_in == CYC_WRITE) wr_count_out <= wr_count_out + 8'h01;
          else push_count_out <= push_count_out + 8'h01;
          wr_addr_out <= bus_addr_in;
          wr_data_out <= bus_wdata_in;
        end
        default: begin
          if (bus_rd_in !== 1'b1) bad_count_out <= bad_count_out + 8'h01;
          if (cyc_kind_in == CYC_VEC) vec_pair_out <= {vec_pair_out[15:0], bus_addr_in};
        end
      endcase
    end
  end
endmodule : bus_watch_model

// ---- sim/cpu_opcode_decoder_tb.sv ----
// Self-checking bench for the opcode decoder and bus cycle sequencer
module cpu_opcode_decoder_tb
  import opdec_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in = 0, srst_in = 1, valid = 0, vreq = 0;
  logic [7:0] opc = 8'h00, vsel = 8'h00, wdata = 8'h5A;
  logic [15:0] oaddr = 16'h0040, sp = 16'h00FF, addr, waddr;
  logic rd, page2, illegal, busy;
  logic [7:0] wdo, bad, wcnt, pcnt, wdat;
  logic [31:0] vpair;
  cyc_e kind;
  op_e op;
  mode_e mode;
  logic [1:0] len;
  logic [3:0] cyc;
  logic [2:0] bitn;
  int err_count = 0, compares = 0;
  op_e ops [16] = '{OP_SUB, OP_COMPARE_A, OP_SUB_BORROW, OP_COMPARE_X, OP_AND, OP_BIT,
                    OP_LOAD_A, OP_STORE_A, OP_XOR_A, OP_ADC, OP_OR_A, OP_ADD, OP_JUMP,
                    OP_JUMP_SUB, OP_LOAD_X, OP_STORE_X};
  // Bus clock
  always #2.5 clk_in = ~clk_in;
  cpu_opcode_decoder u_dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1),
    .opcode_valid_in(valid), .opcode_in(opc), .vector_req_in(vreq), .vector_sel_in(vsel),
    .oper_addr_in(oaddr), .sp_in(sp), .wdata_in(wdata), .bus_addr_out(addr),
    .bus_rd_out(rd), .bus_wdata_out(wdo), .cyc_kind_out(kind), .op_out(op),
    .mode_out(mode), .len_out(len), .cycles_out(cyc), .bitnum_out(bitn),
    .page2_out(page2), .illegal_out(illegal), .busy_out(busy));
  bus_watch_model u_bus (.clk_in(clk_in), .srst_in(srst_in), .bus_addr_in(addr),
    .bus_rd_in(rd), .bus_wdata_in(wdo), .cyc_kind_in(kind), .bad_count_out(bad),
    .wr_count_out(wcnt), .push_count_out(pcnt), .wr_addr_out(waddr),
    .wr_data_out(wdat), .vec_pair_out(vpair));
  task automatic complete_run();
    if (err_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // Bounded wait for the sequencer to go idle
  task automatic wait_idle();
    int i;
    for (i = 0; i < 64 && busy !== 1'b0; i++) @(posedge clk_in) #1;
    if (busy !== 1'b0) begin
      err_count++;
      complete_run();
    end
  endtask : wait_idle
  task automatic run_op(input logic [7:0] code);
    @(posedge clk_in) #1;
    opc = code;
    valid = 1;
    @(posedge clk_in) #1;
    valid = 0;
    wait_idle();
    // Let the far side see the last bus cycle
    @(posedge clk_in) #1;
  endtask : run_op
  task automatic dec_case(input logic [7:0] code, input op_e o, input mode_e m,
                          input logic [1:0] l, input logic [3:0] c);
    run_op(code);
    check(op, o);
    check(mode, m);
    check(len, l);
    check(cyc, c);
    check(illegal, 1'b0);
  endtask : dec_case
  task automatic test_reset();
    check({addr, rd, kind, busy}, {16'h0000, 1'b1, CYC_FREE, 1'b0});
    check({op, illegal}, {OP_NONE, 1'b0});
  endtask : test_reset
  task automatic test_bit_group();
    int i;
    logic [7:0] c;
    for (i = 0; i < 32; i++) begin
      c = i[7:0];
      if (i < 16) dec_case(c, c[0] ? OP_BR_IF_CLR : OP_BR_IF_SET, AM_DIR, 2'h3, 4'h5);
      else dec_case(c, c[0] ? OP_CLR_BIT : OP_SET_BIT, AM_DIR, 2'h2, 4'h5);
      check(bitn, c[3:1]);
    end
  endtask : test_bit_group
  task automatic test_modes();
    int n;
    dec_case(8'h20, OP_BRANCH, AM_REL, 2'h2, 4'h3);
    dec_case(8'h2F, OP_BRANCH, AM_REL, 2'h2, 4'h3);
    dec_case(8'hA6, OP_LOAD_A, AM_CONST, 2'h2, 4'h2);
    dec_case(8'hB4, OP_AND, AM_DIR, 2'h2, 4'h3);
    dec_case(8'hC4, OP_AND, AM_FULL, 2'h3, 4'h4);
    dec_case(8'hD4, OP_AND, AM_IDX_WORD, 2'h3, 4'h4);
    dec_case(8'hE9, OP_ADC, AM_IDX_BYTE, 2'h2, 4'h3);
    dec_case(8'hF9, OP_ADC, AM_IDX, 2'h1, 4'h3);
    dec_case(8'hA7, OP_ADD_SP, AM_CONST, 2'h2, 4'h2);
    dec_case(8'hAF, OP_ADD_X, AM_CONST, 2'h2, 4'h2);
    dec_case(8'hAD, OP_BRANCH_SUB, AM_REL, 2'h2, 4'h5);
    dec_case(8'hF7, OP_STORE_A, AM_IDX, 2'h1, 4'h2);
    for (n = 0; n < 16; n++) begin
      run_op(8'hB0 + n[7:0]);
      check(op, ops[n]);
    end
  endtask : test_modes
  task automatic test_transfers();
    logic [7:0] w0, p0;
    w0 = wcnt;
    run_op(8'hB7);
    check(wcnt, w0 + 8'h01);
    check({waddr, wdat}, {oaddr, wdata});
    p0 = pcnt;
    run_op(8'hCD);
    check(pcnt, p0 + 8'h02);
  endtask : test_transfers
  task automatic test_prefix_illegal();
    run_op(8'h9E);
    run_op(8'hE6);
    check({page2, illegal, op}, {1'b1, 1'b0, OP_NONE});
    run_op(8'hA6);
    check(page2, 1'b0);
    run_op(8'hAC);
    check(illegal, 1'b1);
  endtask : test_prefix_illegal
  task automatic test_vector();
    @(posedge clk_in) #1;
    vsel = 8'hFC;
    vreq = 1;
    @(posedge clk_in) #1;
    vreq = 0;
    wait_idle();
    @(posedge clk_in) #1;
    check(vpair, 32'hFFFC_FFFD);
  endtask : test_vector
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_in);
    #1 srst_in = 0;
    test_reset();
    test_bit_group();
    test_modes();
    test_transfers();
    test_prefix_illegal();
    test_vector();
    check(bad, 8'h00);
    complete_run();
  end
endmodule : cpu_opcode_decoder_tb
